// >>> hw/sar_dev.sv
// Device end: serial word capture and control field decode
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"
module sar_dev
  import sar_pkg::*;
(
  input  wire logic         sys_rst_i,
  sar_link_if.dev           lnk,
  output logic              autotune_en_o,
  output logic [17:0]       autotune_ctrl_o,
  output logic [3:0]        ref_div_ratio_o,
  output logic [5:0]        m_count_o,
  output logic [3:0]        a_count_o,
  output logic              mod_run_o,
  output logic              mod_frac_o,
  output logic [14:0]       modulus_extender_value_o,
  output logic              prescale_16_o,
  output logic              autocal_load_o,
  output logic              freq1_load_o
);

  // ****************************************************************
  // Reset crossing into the link clock
  // ****************************************************************
  logic rst_meta_r;
  logic rst_r;

  // Two-stage sync of the system reset
  always_ff @(posedge lnk.sclk)
  begin
    rst_meta_r <= sys_rst_i;
    rst_r      <= rst_meta_r;
  end

  // ****************************************************************
  // Serial capture
  // ****************************************************************
  sar_word_t shift_r;
  logic      le_q_r;
  logic      latch;
  sar_sel_e  sel;

  // Data and latch enable change off the falling edge of the link
  // clock, so they are sampled directly on its rising edge
  assign latch = lnk.latch_en & ~le_q_r;
  assign sel   = sar_sel_e'(shift_r[`SAR_SEL_HI:0]);

  // Shift in MSB first while latch enable is low
  always_ff @(posedge lnk.sclk)
  begin
    if (rst_r)
    begin
      shift_r <= '0;
    end
    else if (!lnk.latch_en)
    begin
      shift_r <= {shift_r[`SAR_WORD_W-2:0], lnk.sdata};
    end
  end

  // Edge detect on latch enable
  always_ff @(posedge lnk.sclk)
  begin
    if (rst_r)
    begin
      le_q_r <= 1'b0;
    end
    else
    begin
      le_q_r <= lnk.latch_en;
    end
  end

  // ****************************************************************
  // Auto-calibration word
  // ****************************************************************
  logic        ac_en_r;
  logic [17:0] ac_ctrl_r;
  logic        ac_load_r;

  // Capture on select 01, reserved bits dropped
  always_ff @(posedge lnk.sclk)
  begin
    if (rst_r)
    begin
      ac_en_r   <= 1'b0;
      ac_ctrl_r <= '0;
    end
    else if (latch && sel == SAR_AUTOCAL)
    begin
      ac_en_r   <= shift_r[`SAR_AC_EN_BIT];
      ac_ctrl_r <= shift_r[`SAR_AC_CTRL_HI:`SAR_AC_CTRL_LO];
    end
  end

  // ****************************************************************
  // First frequency word
  // ****************************************************************
  logic [1:0] rdiv_r;
  logic [5:0] m_r;
  logic [3:0] a_r;
  logic       run_r;
  logic       frac_r;
  logic [3:0] me_lo_r;
  logic       f1_load_r;

  // Capture on select 10, bits 5:4, 16, 19 and 25:24 not stored
  always_ff @(posedge lnk.sclk)
  begin
    if (rst_r)
    begin
      rdiv_r  <= '0;
      m_r     <= '0;
      a_r     <= '0;
      run_r   <= 1'b0;
      frac_r  <= 1'b0;
      me_lo_r <= '0;
    end
    else if (latch && sel == SAR_FREQ1)
    begin
      rdiv_r  <= shift_r[`SAR_F1_RDIV_HI:`SAR_F1_RDIV_LO];
      m_r     <= shift_r[`SAR_F1_M_HI:`SAR_F1_M_LO];
      a_r     <= shift_r[`SAR_F1_A_HI:`SAR_F1_A_LO];
      run_r   <= shift_r[`SAR_F1_RUN_BIT];
      frac_r  <= shift_r[`SAR_F1_FRAC_BIT];
      me_lo_r <= shift_r[`SAR_F1_ME_HI:`SAR_F1_ME_LO];
    end
  end

  // ****************************************************************
  // Neighbouring words: prescaler mode and extender upper bits
  // ****************************************************************
  logic        pre16_r;
  logic [10:0] me_hi_r;

  // Only the fields this bank decodes are kept
  always_ff @(posedge lnk.sclk)
  begin
    if (rst_r)
    begin
      pre16_r <= 1'b0;
      me_hi_r <= '0;
    end
    else if (latch)
    begin
      if (sel == SAR_OPMODE)
      begin
        pre16_r <= shift_r[`SAR_OM_PRE_BIT];
      end
      else if (sel == SAR_FREQ2)
      begin
        me_hi_r <= shift_r[`SAR_F2_ME_HI:`SAR_F2_ME_LO];
      end
    end
  end

  // ****************************************************************
  // Load strobes
  // ****************************************************************
  // One link cycle pulse after each auto-calibration or first frequency word lands
  always_ff @(posedge lnk.sclk)
  begin
    if (rst_r)
    begin
      ac_load_r <= 1'b0;
      f1_load_r <= 1'b0;
    end
    else
    begin
      ac_load_r <= latch && sel == SAR_AUTOCAL;
      f1_load_r <= latch && sel == SAR_FREQ1;
    end
  end

  // ****************************************************************
  // Decoded outputs
  // ****************************************************************
  logic [3:0] ratio;

  // Reference divider code to ratio
  always_comb
  begin
    ratio = 4'h8;
    case (rdiv_r)
      2'h0: ratio = 4'h8;
      2'h1: ratio = 4'h4;
      2'h2: ratio = 4'h2;
      2'h3: ratio = 4'h1;
      default: ratio = 4'h8;
    endcase
  end

  // Field outputs from the held registers, ratio decoded and A top bit gated by pre16_r
  assign autotune_en_o   = ac_en_r;
  assign autotune_ctrl_o = ac_ctrl_r;
  assign ref_div_ratio_o = ratio;
  assign m_count_o       = m_r;
  // A counter top bit is a don't care in 8/9 mode
  assign a_count_o       = {a_r[3] & pre16_r, a_r[2:0]};
  assign mod_run_o       = run_r;
  assign mod_frac_o      = frac_r;
  assign modulus_extender_value_o = {me_hi_r, me_lo_r};
  assign prescale_16_o   = pre16_r;
  assign autocal_load_o  = ac_load_r;
  assign freq1_load_o    = f1_load_r;

endmodule
`default_nettype wire

// >>> hw/sar_host.sv
// Host end: AXI4-Lite command registers and serial word sender
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"
module sar_host
  import sar_pkg::*;
#(
  parameter int SCLK_HALF = `SAR_SCLK_HALF
)
(
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  sar_link_if.host         lnk,
  input  wire logic [3:0]  s_axi_awaddr_i,
  input  wire logic [2:0]  s_axi_awprot_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [3:0]  s_axi_araddr_i,
  input  wire logic [2:0]  s_axi_arprot_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);

  // ****************************************************************
  // Write channel capture
  // ****************************************************************
  logic        aw_full_r;
  logic [3:0]  aw_addr_r;
  logic        w_full_r;
  logic [31:0] w_data_r;
  logic [31:0] w_mask_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        do_wr;

  assign s_axi_awready_o = ~aw_full_r & ~bvalid_r;
  assign s_axi_wready_o  = ~w_full_r & ~bvalid_r;
  assign do_wr = aw_full_r & w_full_r & ~bvalid_r;

  // Address and data are taken in either order
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || do_wr)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_mask_r  <= '0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_mask_r <= {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                     {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
      end
    end
  end

  // Write response
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= `SAR_RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_r <= 1'b1;
      if (aw_addr_r == `SAR_OFS_DATA || aw_addr_r == `SAR_OFS_CTRL ||
          aw_addr_r == `SAR_OFS_STATUS || aw_addr_r == `SAR_OFS_MEXT)
        bresp_r <= `SAR_RESP_OKAY;
      else
        bresp_r <= `SAR_RESP_SLVERR;
    end
    else if (s_axi_bready_i)
    begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o  = bresp_r;

  // ****************************************************************
  // Command registers
  // ****************************************************************
  logic [31:0] wr_val;
  sar_word_t   data_r;
  logic [14:0] mext_r;
  logic        start_r;
  logic        done_r;
  logic        busy;
  logic        finish;
  sar_tx_e     state_r;

  assign busy = start_r | (state_r != SAR_IDLE);

  // Byte-masked merge of write data with the held word
  always_comb
  begin
    wr_val = (w_data_r & w_mask_r) | (32'(data_r) & ~w_mask_r);
    if (aw_addr_r == `SAR_OFS_MEXT)
      wr_val = (w_data_r & w_mask_r) | (32'(mext_r) & ~w_mask_r);
  end

  // Word and extender registers
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      data_r <= `SAR_RST_DATA;
      mext_r <= `SAR_RST_MEXT;
    end
    else if (do_wr && aw_addr_r == `SAR_OFS_DATA)
      data_r <= wr_val[`SAR_WORD_W-1:0];
    else if (do_wr && aw_addr_r == `SAR_OFS_MEXT)
      mext_r <= wr_val[`SAR_ME_W-1:0];
  end

  // Start request, ignored while a word is in flight
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      start_r <= 1'b0;
    else if (do_wr && aw_addr_r == `SAR_OFS_CTRL && !busy &&
             w_mask_r[`SAR_CTRL_START] && w_data_r[`SAR_CTRL_START])
      start_r <= 1'b1;
    else if (state_r == SAR_SHIFT)
      start_r <= 1'b0;
  end

  // Sticky done, a new finish wins over a clear
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      done_r <= 1'b0;
    else if (finish)
      done_r <= 1'b1;
    else if (do_wr && aw_addr_r == `SAR_OFS_STATUS &&
             w_mask_r[`SAR_ST_DONE] && w_data_r[`SAR_ST_DONE])
      done_r <= 1'b0;
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  assign s_axi_arready_o = ~rvalid_r;

  // One-cycle read answer
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= `SAR_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= `SAR_RESP_OKAY;
      rdata_r  <= '0;
      if (s_axi_araddr_i == `SAR_OFS_DATA)
        rdata_r <= 32'(data_r);
      else if (s_axi_araddr_i == `SAR_OFS_CTRL)
        rdata_r <= '0;
      else if (s_axi_araddr_i == `SAR_OFS_STATUS)
        rdata_r <= {30'h0, done_r, busy};
      else if (s_axi_araddr_i == `SAR_OFS_MEXT)
        rdata_r <= 32'(mext_r);
      else
        rresp_r <= `SAR_RESP_SLVERR;
    end
    else if (s_axi_rready_i)
    begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o  = rdata_r;
  assign s_axi_rresp_o  = rresp_r;

  // ****************************************************************
  // Link clock divider
  // ****************************************************************
  logic [7:0] div_r;
  logic       sclk_r;
  logic       run_r;
  logic       tick;
  logic       fall;

  assign tick = (div_r == 8'(SCLK_HALF - 1));
  assign fall = tick & sclk_r;

  // Marks the divider as seeded once reset has been seen
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      run_r <= 1'b1;
  end

  // Divided clock keeps running through reset so the device end gets
  // the edges its reset synchroniser needs; seeded on first reset edge
  always_ff @(posedge core_clk_i)
  begin
    if (run_r && tick)
    begin
      div_r  <= '0;
      sclk_r <= ~sclk_r;
    end
    else if (run_r)
      div_r <= div_r + 8'h1;
    else
    begin
      div_r  <= '0;
      sclk_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Word builder and sender
  // ****************************************************************
  sar_word_t tx_word;
  sar_word_t sh_r;
  logic [4:0] cnt_r;
  logic       le_r;

  // Reserved bits cleared, bit 19 forced and extender spliced in
  always_comb
  begin
    tx_word = data_r;
    case (data_r[`SAR_SEL_HI:0])
      `SAR_SEL_OPMODE: tx_word = data_r & `SAR_KEEP_OPMODE;
      `SAR_SEL_AUTOCAL: tx_word = data_r & `SAR_KEEP_AUTOCAL;
      `SAR_SEL_FREQ1:
      begin
        tx_word = data_r & `SAR_KEEP_FREQ1;
        tx_word[`SAR_F1_ONE_BIT] = 1'b1;
        tx_word[`SAR_F1_ME_HI:`SAR_F1_ME_LO] = mext_r[3:0];
      end
      default:
      begin
        tx_word = data_r & `SAR_KEEP_FREQ2;
        tx_word[`SAR_F2_ME_HI:`SAR_F2_ME_LO] = mext_r[14:4];
      end
    endcase
  end

  assign finish = fall && state_r == SAR_LATCH;

  // Bits change on falling edges, MSB first, then one latch period
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= SAR_IDLE;
      sh_r    <= '0;
      cnt_r   <= '0;
      le_r    <= 1'b0;
    end
    else if (fall)
    begin
      case (state_r)
        SAR_IDLE:
          if (start_r)
          begin
            sh_r    <= tx_word;
            cnt_r   <= 5'(`SAR_WORD_W - 1);
            state_r <= SAR_SHIFT;
          end
        SAR_SHIFT:
          if (cnt_r == 5'h0)
          begin
            le_r    <= 1'b1;
            state_r <= SAR_LATCH;
          end
          else
          begin
            sh_r  <= {sh_r[`SAR_WORD_W-2:0], 1'b0};
            cnt_r <= cnt_r - 5'h1;
          end
        default:
        begin
          le_r    <= 1'b0;
          state_r <= SAR_IDLE;
        end
      endcase
    end
  end

  assign lnk.sclk     = sclk_r;
  assign lnk.sdata    = sh_r[`SAR_WORD_W-1];
  assign lnk.latch_en = le_r;

endmodule
`default_nettype wire

// >>> pkg/sar_consts.svh
// Constants for the synthesizer control word bank and its host
//
// What this block does
// - Select bits 01 steer into auto-calibration word
// - Select bits 10 steer into first frequency word
// - Bit 20 enables VCO automatic tuning
// - Bits 3:2 pick reference divide 8,4,2,1
// - Bits 15:10 give M, bits 9:6 A
// - In 8/9 mode A uses three bits
// - Bit 17 zero resets modulator, one normal
// - Bit 18 zero integer mode, one fractional
// - Host always sends bit 19 high in first frequency words
// - Bits 23:20 give extender bits 3:0
// - Host sends extender nibble consistent with upper bits
// - Word three bits 12:2 give extender 14:4
// - Mode word bit 23 picks 8/9 or 16/17
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH

// ****************************************************************
// Serial word layout
// ****************************************************************
`define SAR_WORD_W       26
`define SAR_SEL_HI       1
`define SAR_SEL_OPMODE   2'h0
`define SAR_SEL_AUTOCAL  2'h1
`define SAR_SEL_FREQ1    2'h2
`define SAR_SEL_FREQ2    2'h3
`define SAR_AC_CTRL_HI   19
`define SAR_AC_CTRL_LO   2
`define SAR_AC_EN_BIT    20
`define SAR_F1_RDIV_HI   3
`define SAR_F1_RDIV_LO   2
`define SAR_F1_M_HI      15
`define SAR_F1_M_LO      10
`define SAR_F1_A_HI      9
`define SAR_F1_A_LO      6
`define SAR_F1_RUN_BIT   17
`define SAR_F1_FRAC_BIT  18
`define SAR_F1_ONE_BIT   19
`define SAR_F1_ME_HI     23
`define SAR_F1_ME_LO     20
`define SAR_F2_ME_HI     12
`define SAR_F2_ME_LO     2
`define SAR_OM_PRE_BIT   23
`define SAR_ME_W         15
// Bits the host may pass per word kind, everything else is reserved
`define SAR_KEEP_OPMODE  26'h0e3fdff
`define SAR_KEEP_AUTOCAL 26'h01fffff
`define SAR_KEEP_FREQ1   26'h0feffcf
`define SAR_KEEP_FREQ2   26'h01fffff

// ****************************************************************
// Host registers and timing
// ****************************************************************
`define SAR_OFS_DATA     4'h0
`define SAR_OFS_CTRL     4'h4
`define SAR_OFS_STATUS   4'h8
`define SAR_OFS_MEXT     4'hc
`define SAR_CTRL_START   0
`define SAR_ST_BUSY      0
`define SAR_ST_DONE      1
`define SAR_RST_DATA     26'h0000000
`define SAR_RST_MEXT     15'h0000
`define SAR_SCLK_HALF    2
`define SAR_RESP_OKAY    2'h0
`define SAR_RESP_SLVERR  2'h2

`endif

// >>> pkg/sar_link_if.sv
// Three-wire serial link between host and word bank
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
  logic sclk;
  logic sdata;
  logic latch_en;
  modport host (output sclk, output sdata, output latch_en);
  modport dev  (input sclk, input sdata, input latch_en);
endinterface
`default_nettype wire

// >>> pkg/sar_pkg.sv
// Types shared by both ends of the control word link
package sar_pkg;
  typedef logic [25:0] sar_word_t;
  typedef enum logic [1:0] {
    SAR_OPMODE,
    SAR_AUTOCAL,
    SAR_FREQ1,
    SAR_FREQ2
  } sar_sel_e;
  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_SHIFT,
    SAR_LATCH
  } sar_tx_e;
endpackage

// >>> sim/sar_link_asserts.sv
// Checker for the serial link between host and word bank
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"
module sar_link_asserts
(
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic sclk,
  input  wire logic sdata,
  input  wire logic latch_en
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic [25:0] sh_r;
  logic [4:0]  cnt_r;

  // Shadow of the bits shifted in while latch is low
  always_ff @(posedge sclk or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sh_r <= 26'h0;
    else if (!latch_en)
      sh_r <= {sh_r[24:0], sdata};
  end

  // Bits seen since the last latch, saturating
  always_ff @(posedge sclk or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cnt_r <= 5'h0;
    else if (latch_en)
      cnt_r <= 5'h0;
    else if (cnt_r != 5'h1f)
      cnt_r <= cnt_r + 5'h1;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sclk_high_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(sclk) |-> sclk [*2] ##1 !sclk)
    else $error("link clock high phase wrong");
  sclk_low_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(sclk) |-> !sclk [*2] ##1 sclk)
    else $error("link clock low phase wrong");
  latch_once_a: assert property (
    @(posedge sclk) disable iff (sys_rst_i)
    $rose(latch_en) |=> !latch_en)
    else $error("latch enable longer than one period");
  frame_len_a: assert property (
    @(posedge sclk) disable iff (sys_rst_i)
    $rose(latch_en) |-> cnt_r >= 5'd26)
    else $error("latch before a full word");
  autocal_rsvd_a: assert property (
    @(posedge sclk) disable iff (sys_rst_i)
    $rose(latch_en) && sh_r[1:0] == 2'h1
    |-> (sh_r & ~`SAR_KEEP_AUTOCAL) == 26'h0)
    else $error("reserved bits set in auto-cal word");
  freq1_one_a: assert property (
    @(posedge sclk) disable iff (sys_rst_i)
    $rose(latch_en) && sh_r[1:0] == 2'h2 |-> sh_r[19])
    else $error("bit 19 low in frequency word");
  freq1_rsvd_a: assert property (
    @(posedge sclk) disable iff (sys_rst_i)
    $rose(latch_en) && sh_r[1:0] == 2'h2
    |-> (sh_r & ~`SAR_KEEP_FREQ1) == 26'h0)
    else $error("reserved bits set in frequency word");
  other_rsvd_a: assert property (
    @(posedge sclk) disable iff (sys_rst_i)
    $rose(latch_en) && sh_r[1] == sh_r[0]
    |-> (sh_r & ~(sh_r[0] ? `SAR_KEEP_FREQ2 : `SAR_KEEP_OPMODE))
        == 26'h0)
    else $error("reserved bits set in mode or second word");

  // Main scenarios
  cover property (@(posedge sclk) $rose(latch_en) && sh_r[1:0] == 2'h1);
  cover property (@(posedge sclk) $rose(latch_en) && sh_r[1:0] == 2'h2);
  cover property (@(posedge sclk) $rose(latch_en) && sh_r[1:0] == 2'h3);
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the host and word bank joined by the link
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"
module testbench
  import sar_pkg::*;
;
  logic        core_clk_i, sys_rst_i;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, st;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic        at_en, m_run, m_frac, pre16_o, ac_ld, f1_ld, pre16;
  logic [17:0] at_ctrl;
  logic [3:0]  ratio, a_cnt;
  logic [5:0]  m_cnt;
  logic [14:0] mext, me_o;
  sar_word_t   w, aw;
  logic [30:0] fw;
  sar_word_t   ac_q[$];
  logic [30:0] f1_q[$];
  int          num_errors, checked, p, r;

  sar_link_if lnk();
  sar_host #(.SCLK_HALF(2)) i_sar_host (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .lnk(lnk), .s_axi_awaddr_i(awaddr),
    .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  sar_dev i_sar_dev (.sys_rst_i(sys_rst_i), .lnk(lnk),
    .autotune_en_o(at_en), .autotune_ctrl_o(at_ctrl),
    .ref_div_ratio_o(ratio), .m_count_o(m_cnt), .a_count_o(a_cnt),
    .mod_run_o(m_run), .mod_frac_o(m_frac),
    .modulus_extender_value_o(me_o), .prescale_16_o(pre16_o),
    .autocal_load_o(ac_ld), .freq1_load_o(f1_ld));
  sar_link_asserts i_sar_link_asserts (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .sclk(lnk.sclk), .sdata(lnk.sdata),
    .latch_en(lnk.latch_en));

  // ****************************************************************
  // Report and bus tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang(input int n);
    if (n >= 100)
    begin
      num_errors++;
      complete_run();
    end
  endtask

  // Write with both channels offered together, then the response
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int   n;
    logic awp, wp, hit_a, hit_w, hit_b;
    awp = 1'b1;
    wp = 1'b1;
    hit_b = 1'b0;
    @(posedge core_clk_i);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
    for (n = 0; n < 100 && (awp || wp); n++)
    begin
      @(negedge core_clk_i);
      hit_a = awp && awready === 1'b1;
      hit_w = wp && wready === 1'b1;
      @(posedge core_clk_i);
      if (hit_a) begin awvalid <= 1'b0; awp = 1'b0; end
      if (hit_w) begin wvalid <= 1'b0; wp = 1'b0; end
    end
    hang(n);
    bready <= 1'b1;
    for (n = 0; n < 100 && !hit_b; n++)
    begin
      @(negedge core_clk_i);
      hit_b = bvalid === 1'b1;
      if (hit_b) check(bresp, `SAR_RESP_OKAY);
      @(posedge core_clk_i);
    end
    hang(n);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int   n;
    logic hit_a, hit_r;
    hit_a = 1'b0;
    hit_r = 1'b0;
    @(posedge core_clk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 100 && !hit_r; n++)
    begin
      @(negedge core_clk_i);
      hit_a = hit_a || arready === 1'b1;
      hit_r = rvalid === 1'b1;
      d = rdata;
      if (hit_r) check(rresp, `SAR_RESP_OKAY);
      @(posedge core_clk_i);
      if (hit_a) arvalid <= 1'b0;
    end
    hang(n);
    rready <= 1'b0;
  endtask

  // Send one word through the host, noting the expected decode
  task automatic send(input sar_word_t wd, input logic [14:0] mx);
    int n;
    if (wd[1:0] == 2'h1) ac_q.push_back(wd);
    if (wd[1:0] == 2'h2) f1_q.push_back({pre16, mx[3:0], wd});
    axi_wr(`SAR_OFS_MEXT, {17'h0, mx});
    axi_wr(`SAR_OFS_DATA, {6'h0, wd});
    axi_wr(`SAR_OFS_CTRL, 32'h1);
    for (n = 0; n < 100; n++)
    begin
      axi_rd(`SAR_OFS_STATUS, st);
      if (st[1] === 1'b1) break;
    end
    hang(n);
    axi_wr(`SAR_OFS_STATUS, 32'h2);
  endtask

  // ****************************************************************
  // Monitor of the load pulses
  // ****************************************************************
  always @(negedge lnk.sclk)
  begin
    if (ac_ld === 1'b1)
    begin
      aw = ac_q.pop_front();
      check(aw[1:0], 2'h1);
      check(at_en, aw[20]);
      check(at_ctrl, aw[19:2]);
    end
    if (f1_ld === 1'b1)
    begin
      fw = f1_q.pop_front();
      check(ratio, 4'h8 >> fw[3:2]);
      check(m_cnt, fw[15:10]);
      check(a_cnt, fw[30] ? fw[9:6] : {1'b0, fw[8:6]});
      check(m_run, fw[17]);
      check(m_frac, fw[18]);
      check(me_o[3:0], fw[29:26]);
    end
  end

  // Clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    sys_rst_i = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 4'h0; araddr = 4'h0;
    wdata = 32'h0; pre16 = 1'b0; num_errors = 0; checked = 0;
    void'($urandom(86));
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    axi_rd(`SAR_OFS_DATA, st);
    check(st, 32'h0);
    axi_rd(`SAR_OFS_MEXT, st);
    check(st, 32'h0);
    axi_rd(`SAR_OFS_STATUS, st);
    check(st, 32'h0);
    $display("test reset values done");
    // Both prescaler modes, every divider code and modulator setting
    for (p = 0; p < 2; p++)
    begin
      w = 26'($urandom) & `SAR_KEEP_OPMODE;
      w[23] = p[0];
      w[1:0] = 2'h0;
      pre16 = p[0];
      send(w, 15'h0);
      check(pre16_o, p[0]);
      for (r = 0; r < 4; r++)
      begin
        w = 26'($urandom);
        w[1:0] = 2'h2;
        w[3:2] = r[1:0];
        w[17] = r[0];
        w[18] = r[1];
        mext = 15'($urandom);
        send(w, mext);
        w = 26'($urandom);
        w[1:0] = 2'h3;
        send(w, mext);
        check(me_o, mext);
        check(me_o[14:4], mext[14:4]);
      end
      $display("test frequency words done");
    end
    // Auto-tune on and off, reserved bits filled at random
    for (p = 0; p < 2; p++)
    begin
      w = 26'($urandom);
      w[1:0] = 2'h1;
      w[20] = p[0];
      send(w, 15'($urandom));
    end
    $display("test auto-cal words done");
    check(ac_q.size() + f1_q.size(), 0);
    complete_run();
  end
endmodule
`default_nettype wire
